// ===== hdl/epc_pkg.sv
// constants and carrier types for the otp array program control block
package epc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 16'h001D;
  localparam int unsigned LATCH_BIT = 2;
  localparam int unsigned PULSE_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] USER_BASE = 16'h8000;
  localparam logic [ADDR_W-1:0] USER_LAST = 16'hFDFF;
  localparam logic [ADDR_W-1:0] VECT_BASE = 16'hFFF0;
  localparam logic [ADDR_W-1:0] VECT_LAST = 16'hFFFF;
  localparam int unsigned BLOCK_BYTES = 16;
  localparam int unsigned BLOCK_LSB = 4;
  localparam logic [DATA_W-1:0] READ_BLOCKED = 8'h00;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } epc_bus_s;
endpackage

// ===== hdl/epc_latch.sv
// storage of one block of latched program bytes
`timescale 1ns/100ps
module epc_latch (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic clr, // clear all slot written flags except a slot written this cycle, bytes kept
  input wire logic wr, // capture a byte
  input wire logic [3:0] idx, // byte slot in block
  input wire logic [7:0] wdata, // byte to capture
  output logic [127:0] data_q, // latched bytes
  output logic [15:0] valid_q // slot written flags
);
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_slot
      // one flop set per slot, so no process shares a variable with another
      logic [7:0] byte_q;
      logic flag_q;
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          byte_q <= 8'h00;
          flag_q <= 1'b0;
        end else if (wr && idx == 4'(g)) begin
          byte_q <= wdata;
          flag_q <= 1'b1;
        end else if (clr) begin
          flag_q <= 1'b0;
        end
      end
      assign data_q[g*8 +: 8] = byte_q;
      assign valid_q[g] = flag_q;
    end
  endgenerate
endmodule // epc_latch

// ===== hdl/epc_ctrl.sv
// top of the otp array program control block
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module epc_ctrl (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [15:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata_q, // register read data
  input wire logic [15:0] arr_addr, // cpu array address
  input wire logic [7:0] arr_wdata, // cpu array write data
  input wire logic arr_wr, // cpu array write strobe
  input wire logic arr_rd, // cpu array read strobe
  output logic [7:0] arr_rdata_q, // cpu array read data
  input wire logic [7:0] cell_rdata, // byte from array cells
  output logic [15:0] cell_addr, // address to array cells
  output logic prog_mode, // array paths in program setup
  output logic prog_power, // programming supply on
  output logic [15:0] prog_block_q, // latched block base
  output logic [127:0] prog_data, // latched block bytes
  output logic [15:0] prog_valid // latched slot flags
);
  logic latch_enable_q;
  logic latch_enable_d;
  logic program_pulse_q;
  logic program_pulse_d;
  logic [15:0] blk_q;
  logic have_blk_q;

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= epc_pkg::USER_BASE && a <= epc_pkg::USER_LAST) ||
               (a >= epc_pkg::VECT_BASE && a <= epc_pkg::VECT_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  wire ctrl_hit = reg_addr == epc_pkg::CTRL_OFFSET;
  wire ctrl_wr = reg_wr && ctrl_hit;
  wire w_latch = reg_wdata[epc_pkg::LATCH_BIT];
  wire w_pulse = reg_wdata[epc_pkg::PULSE_BIT];
  wire [15:0] arr_blk = {arr_addr[15:epc_pkg::BLOCK_LSB], 4'h0};
  // a write outside the first latched block is dropped, not mixed in
  wire same_blk = !have_blk_q || arr_blk == blk_q;
  wire cap_wr = arr_wr && latch_enable_q && in_array(arr_addr) && same_blk;

  always_comb begin
    latch_enable_d = latch_enable_q;
    program_pulse_d = program_pulse_q;
    if (ctrl_wr) begin
      if (!w_latch) begin
        latch_enable_d = 1'b0;
        program_pulse_d = 1'b0;
      end else if (!latch_enable_q) begin
        latch_enable_d = 1'b1;
        program_pulse_d = 1'b0;
      end else begin
        program_pulse_d = w_pulse;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latch_enable_q <= epc_pkg::CTRL_RESET[epc_pkg::LATCH_BIT];
      program_pulse_q <= epc_pkg::CTRL_RESET[epc_pkg::PULSE_BIT];
    end else begin
      latch_enable_q <= latch_enable_d;
      program_pulse_q <= program_pulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blk_q <= 16'h0000;
      have_blk_q <= 1'b0;
    end else if (!latch_enable_q) begin
      have_blk_q <= 1'b0;
    end else if (cap_wr && !have_blk_q) begin
      blk_q <= arr_blk;
      have_blk_q <= 1'b1;
    end
  end

  epc_latch u_latch (
    .core_clk(core_clk),
    .rst(rst),
    .clr(!latch_enable_q),
    .wr(cap_wr),
    .idx(arr_addr[3:0]),
    .wdata(arr_wdata),
    .data_q(prog_data),
    .valid_q(prog_valid)
  );

  assign prog_block_q = blk_q;
  assign prog_mode = latch_enable_q;
  assign prog_power = program_pulse_q;
  // programming addresses come from the latch, reads from the cpu
  assign cell_addr = latch_enable_q ? blk_q : arr_addr;

  ////////////////////////////////////////////////////////////////////////
  wire [7:0] ctrl_val = 8'(({7'h00, latch_enable_q} << epc_pkg::LATCH_BIT) |
                           ({7'h00, program_pulse_q} << epc_pkg::PULSE_BIT));
  wire arr_ok = arr_rd && !latch_enable_q && in_array(arr_addr);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
      arr_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= (reg_rd && ctrl_hit) ? ctrl_val : 8'h00;
      arr_rdata_q <= arr_ok ? cell_rdata : epc_pkg::READ_BLOCKED;
    end
  end
endmodule // epc_ctrl

// ===== tb/epc_cells.sv
// array cell contents model
`timescale 1ns/100ps
module epc_cells (
  input wire logic [15:0] cell_addr, // address
  output logic [7:0] cell_rdata // byte
);
  // pattern differs per low address byte so a stale byte shows
  assign cell_rdata = cell_addr[7:0] ^ 8'h3C;
endmodule // epc_cells

// ===== tb/epc_sva.sv
// port assertions for the program control block
`timescale 1ns/100ps
module epc_sva (
  input wire logic core_clk, // clk
  input wire logic rst, // reset
  input wire logic [15:0] reg_addr, // addr
  input wire logic [7:0] reg_wdata, // data
  input wire logic reg_wr, // write
  input wire logic [15:0] arr_addr, // addr
  input wire logic arr_rd, // read
  input wire logic [7:0] arr_rdata_q, // data
  input wire logic [7:0] cell_rdata, // cell
  input wire logic prog_mode, // latch
  input wire logic prog_power // pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire w = reg_wr && reg_addr == 16'h001D;
  wire ok = arr_addr >= 16'h8000 && arr_addr <= 16'hFDFF || arr_addr >= 16'hFFF0;
  property p_one; $rose(prog_mode) |-> !prog_power; endproperty
  a_one: assert property (p_one) else $error("both bits set");
  property p_pre; $rose(prog_power) |-> $past(prog_mode); endproperty
  a_pre: assert property (p_pre) else $error("pulse without latch");
  property p_clr; w && !reg_wdata[2] |=> !prog_mode && !prog_power; endproperty
  a_clr: assert property (p_clr) else $error("pulse kept");
  property p_pwr; w && prog_mode && reg_wdata[2] |=> prog_power == $past(reg_wdata[0]); endproperty
  a_pwr: assert property (p_pwr) else $error("power wrong");
  property p_lat; w |=> prog_mode == $past(reg_wdata[2]); endproperty
  a_lat: assert property (p_lat) else $error("latch wrong");
  property p_nrd; arr_rd && prog_mode |=> arr_rdata_q == 8'h00; endproperty
  a_nrd: assert property (p_nrd) else $error("read while latched");
  property p_rd; arr_rd && !prog_mode && ok |=> arr_rdata_q == $past(cell_rdata); endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_gap; arr_rd && !ok |=> arr_rdata_q == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  c_pgm: cover property ($rose(prog_power));
  c_blk: cover property (arr_rd && prog_mode);
  c_vec: cover property (arr_rd && arr_addr >= 16'hFFF0 && !prog_mode);
endmodule // epc_sva

// ===== tb/epc_ctrl_bench.sv
// self-checking bench for the program control block
`timescale 1ns/100ps
module epc_ctrl_bench;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, arr_wr = 0, arr_rd = 0, seen = 0;
  logic prog_mode, prog_power;
  logic [15:0] reg_addr = '0, arr_addr = '0, a, cell_addr, prog_block_q, prog_valid;
  logic [7:0] reg_wdata = '0, arr_wdata = '0, reg_rdata_q, arr_rdata_q, cell_rdata;
  logic [127:0] prog_data;
  logic [31:0] s = 32'hACD21395;
  logic [8:0] q[$];
  int err_count = 0, total_checks = 0;
  always #20 core_clk = ~core_clk;
  epc_ctrl u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .arr_addr, .arr_wdata, .arr_wr, .arr_rd, .arr_rdata_q, .cell_rdata, .cell_addr,
    .prog_mode, .prog_power, .prog_block_q, .prog_data, .prog_valid);
  epc_cells u_cells (.cell_addr, .cell_rdata);
  function automatic logic [31:0] xs(logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  task chk(logic [7:0] g, logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task bus(int k, logic [15:0] ad, logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, arr_addr, reg_wdata, arr_wdata} <= {ad, ad, d, d};
    {reg_wr, reg_rd, arr_wr, arr_rd} <= 4'h8 >> k;
    @(posedge core_clk);
    {reg_wr, reg_rd, arr_wr, arr_rd} <= 4'h0;
  endtask
  task rd(int k, logic [15:0] ad, logic [7:0] e);
    q.push_back({k == 3, e});
    bus(k, ad, 8'h00);
  endtask
  task report_and_stop;
    if (q.size() != 0) err_count++;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // read data stand one cycle: note the strobe, compare mid-cycle
  always @(posedge core_clk) seen <= reg_rd | arr_rd;
  always @(negedge core_clk) if (seen) begin
    chk(q[0][8] ? arr_rdata_q : reg_rdata_q, q[0][7:0]);
    void'(q.pop_front());
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(1, 16'h001D, 8'h00);
    bus(0, 16'h001D, 8'h01);
    rd(1, 16'h001D, 8'h00);
    bus(0, 16'h001D, 8'h05);
    rd(1, 16'h001D, 8'h04);
    rd(3, 16'h8013, 8'h00);
    bus(2, 16'h8013, 8'h5A);
    bus(2, 16'h8023, 8'h77);
    @(negedge core_clk);
    chk(prog_data[31:24], 8'h5A);
    chk(prog_block_q[7:0], 8'h10);
    chk({7'h00, prog_mode}, 8'h01);
    chk(cell_addr[7:0], 8'h10);
    chk({7'h00, prog_power}, 8'h00);
    bus(0, 16'h001D, 8'h05);
    rd(1, 16'h001D, 8'h05);
    @(negedge core_clk);
    chk({7'h00, prog_power}, 8'h01);
    bus(0, 16'h001D, 8'h00);
    rd(1, 16'h001D, 8'h00);
    bus(2, 16'h8045, 8'hEE);
    rd(1, 16'h001C, 8'h00);
    chk(prog_valid[7:0], 8'h00);
    chk({6'h00, prog_mode, prog_power}, 8'h00);
    for (int i = 0; i < 24; i++) begin
      s = xs(s);
      a = i < 4 ? {12'hFFF, s[3:0]} : s[15:0];
      rd(3, a, (a >= 16'h8000 && a <= 16'hFDFF || a >= 16'hFFF0) ? a[7:0] ^ 8'h3C : 8'h00);
    end
    repeat (3) @(posedge core_clk);
    report_and_stop;
  end
endmodule // epc_ctrl_bench
bind epc_ctrl epc_sva u_sva (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .arr_addr,
  .arr_rd, .arr_rdata_q, .cell_rdata, .prog_mode, .prog_power);
